/* hdl/sac_pkg.sv */
/* sac_pkg: codes, field layouts, reset values and state codes of the
   audio serial output and control port.
   Assumes every design file imports it whole. */
package sac_pkg;
  // sample format codes
  localparam logic [2:0] SF_LJ24 = 3'h5;
  localparam logic [2:0] SF_I2S24 = 3'h4;
  localparam logic [2:0] SF_RJ24 = 3'h0;
  localparam logic [2:0] SF_RJ16 = 3'h3;
  // link role codes
  localparam logic [1:0] ROLE_SLAVE = 2'h0;
  localparam logic [1:0] ROLE_M256 = 2'h1;
  localparam logic [1:0] ROLE_M384 = 2'h2;
  // register indexes
  localparam logic [6:0] AT_GAIN = 7'h31;
  localparam logic [6:0] AT_CHAN = 7'h32;
  localparam logic [6:0] AT_MODE = 7'h33;
  // control word layout
  localparam int CW_TOP = 15;
  localparam int IX_LSB = 8;
  localparam int IX_W = 7;
  localparam logic [4:0] CW_LAST = 5'h0F;
  // field positions and widths
  localparam int RESTORE_BIT = 6;
  localparam int BYPASS_BIT = 7;
  localparam int RSYNC_BIT = 6;
  localparam int ROLE_LSB = 3;
  localparam int ROLE_W = 2;
  localparam int GAIN_W = 6;
  localparam int CHAN_W = 3;
  localparam int SF_W = 3;
  // reset values; gain and channel codes are plain defaults
  localparam logic [5:0] GAIN_RST = 6'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [2:0] SF_RST = SF_I2S24;
  localparam logic [1:0] ROLE_RST = ROLE_SLAVE;
  // framing
  localparam logic [5:0] HALF64 = 6'h20;
  localparam logic [5:0] HALF48 = 6'h18;
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] WORD24 = 6'h18;
  localparam logic [5:0] WORD16 = 6'h10;
  // drift limits in bit clocks for 64 and 48 bit frames
  localparam logic [2:0] LIM64 = 3'h6;
  localparam logic [2:0] LIM48 = 3'h5;
  // master bit clock half periods in system clocks
  localparam logic [2:0] HP256 = 3'h2;
  localparam logic [2:0] HP384 = 3'h3;
  localparam logic [2:0] HP512 = 3'h4;
  // sample values
  localparam logic [23:0] ZERO_CODE = 24'h000000;
  localparam logic [23:0] SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] SAT_NEG = 24'h800000;
  localparam int HPF_FRAC = 8;
  // link lock states
  typedef enum logic [2:0] {
    SYN_ACQ = 3'b001,
    SYN_MEAS = 3'b010,
    SYN_RUN = 3'b100
  } sac_sync_t;
endpackage

/* hdl/sac_sync2.sv */
/* sac_sync2: two-flop level synchroniser, one per bit.
   Assumes its inputs are levels held for several destination clocks. */
`timescale 1ns/10ps
module sac_sync2
  import sac_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule // sac_sync2

/* hdl/sac_audio_port.sv */
/* sac_audio_port: serial sample output, link clock master/slave logic,
   lock supervision, overflow flag, dc filter and 16-bit control port.
   Assumes samples, overflow strobes and nrst come on clock; the control
   pins and link pins are asynchronous; system_clock_in is the link clock
   and frame_clock_in is locked to it in the slave role. */
`timescale 1ns/10ps
// Operation
// R1: code 101 left-justified, 100 I2S, 24-bit.
// R2: code 000 right-justified 24, 011 right 16.
// R3: data changes after bit clock fall, frame edge.
// R4: master frame clock changes after bit clock fall.
// R5: slave frame clock sampled on bit clock rise; here its edges are taken on every system clock.
// R6: slave frame clock locked to system clock.
// R7: drift beyond 6 or 5 bits loses sync.
// R8: lost sync outputs zero until relocked.
// R9: drift below 5 or 4 bits tolerated.
// R10: host holds reset while changing rate, modes.
// R11: reset low initialises, disables data output.
// R12: overflow flag held at least 8192 sample periods.
// R13: bypass 0 removes dc, 1 passes dc.
// R14: resync bit 0 holds resync, 1 runs.
// R15: host changes modes only with resync low.
// R16: restore bit 0 reloads all control defaults.
// R17: control word: zero, 7-bit index, 8-bit value.
// R18: host idles select high, lowers to write.
// R19: host gives sixteen control clocks per word.
// R20: after sixteenth clock, value latched into register.
// R21: select returns high between words.
// R22: sample data on rise, MSB first, drop bad index.
// R23: role 00 slave; others master 256/384/512.
// R24: master drives clocks, 64 bit clocks per frame.
// R25: slave accepts 64, or 48 bit frames.
// R26: registers 31h, 32h, 33h field layout.
module sac_audio_port
  import sac_pkg::*;
#(
  parameter logic [13:0] OVF_HOLD = 14'h2000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic system_clock_in,
  input wire logic ctrl_select_n,
  input wire logic ctrl_clock,
  input wire logic ctrl_data_in,
  input wire logic [23:0] sample_left,
  input wire logic [23:0] sample_right,
  input wire logic sample_valid,
  input wire logic overflow_left,
  input wire logic overflow_right,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  output logic data_out,
  output logic data_out_oe,
  output logic overflow_flag,
  output logic [5:0] gain_setting,
  output logic [2:0] input_channel_select,
  output logic dc_filter_bypass,
  output logic resync_request_n,
  output logic [1:0] link_role_select,
  output logic [2:0] sample_format
);
  typedef struct packed {
    logic clk_q;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic done;
    logic [5:0] gain;
    logic [2:0] chan;
    logic bypass;
    logic rsn;
    logic [1:0] role;
    logic [2:0] sf;
    logic [31:0] avl;
    logic [31:0] avr;
    logic [23:0] cl;
    logic [23:0] cr;
    logic [23:0] hl;
    logic [23:0] hr;
    logic req_q;
    logic ack;
    logic [13:0] ocnt;
    logic ovf;
  } sac_main_t;

  typedef struct packed {
    logic bit_q;
    logic frm_q;
    logic ack_q;
    sac_sync_t st;
    logic [2:0] div;
    logic bo;
    logic fo;
    logic [5:0] pos;
    logic [5:0] half;
    logic [9:0] per;
    logic [9:0] ph;
    logic [4:0] bper;
    logic [4:0] bcnt;
    logic req;
    logic [23:0] nl;
    logic [23:0] nr;
    logic [23:0] wl;
    logic [23:0] wr;
    logic dout;
    logic oe;
    logic boe;
  } sac_link_t;

  sac_main_t main_r, main_nxt;
  sac_link_t link_r, link_nxt;
  logic [3:0] msy;
  logic [9:0] lsy;
  logic sel_s, cck_s, cdat_s, req_s;
  logic bit_s, frm_s, ack_s, l_rsn, l_nrst;
  logic [1:0] l_role;
  logic [2:0] l_sf;
  logic [15:0] word;
  logic [6:0] ix;
  logic wr_en, ok_at, tick, ovf_ev;
  logic [23:0] est_l, est_r;
  logic [24:0] dl, dr;
  logic master, fall, rise, lre, lv, left, fs, lost, mute, bitv, inr, ev;
  logic [2:0] hp, lm;
  logic [5:0] hsz, st0, wn, k;
  logic [9:0] e, dev;
  logic [7:0] lim;
  logic [23:0] w;

  // clamp a filter difference back into the sample range
  function automatic logic [23:0] sat24(input logic [24:0] v);
    if (v[24] != v[23]) begin
      sat24 = v[24] ? SAT_NEG : SAT_POS;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // control pins and the frame request enter the main clock here
  sac_sync2 #(.W(4)) u_main_sync (
    .clk(clock),
    .d({ctrl_select_n, ctrl_clock, ctrl_data_in, link_r.req}),
    .q(msy)
  );
  assign {sel_s, cck_s, cdat_s, req_s} = msy;

  // link pins, settings and the answer toggle enter the link clock here
  sac_sync2 #(.W(10)) u_link_sync (
    .clk(system_clock_in),
    .d({nrst, main_r.rsn, main_r.role, main_r.sf, main_r.ack,
        frame_clock_in, bit_clock_in}),
    .q(lsy)
  );
  assign {l_nrst, l_rsn, l_role, l_sf, ack_s, frm_s, bit_s} = lsy;

  // control port, settings, dc filter, sample hand-off and overflow
  always_comb begin
    main_nxt = main_r;
    wr_en = 1'b0;
    tick = 1'b0;
    word = {main_r.sh[14:0], cdat_s};
    ix = word[IX_LSB +: IX_W];
    main_nxt.clk_q = cck_s;
    if (sel_s) begin
      main_nxt.cnt = '0; // R21
      main_nxt.done = 1'b0;
    end else if (cck_s && !main_r.clk_q && !main_r.done) begin
      main_nxt.sh = word; // R22
      main_nxt.cnt = main_r.cnt + 5'h01;
      if (main_r.cnt == CW_LAST) begin
        main_nxt.done = 1'b1;
        wr_en = 1'b1; // R20
      end
    end
    ok_at = !word[CW_TOP] && (ix == AT_GAIN || ix == AT_CHAN ||
      ix == AT_MODE); // R17 R22
    if (wr_en && ok_at) begin
      if (ix == AT_GAIN) begin
        main_nxt.gain = word[0 +: GAIN_W]; // R26
      end else if (ix == AT_CHAN) begin
        main_nxt.chan = word[0 +: CHAN_W]; // R26
      end else begin
        main_nxt.bypass = word[BYPASS_BIT]; // R26
        main_nxt.rsn = word[RSYNC_BIT]; // R14
        main_nxt.role = word[ROLE_LSB +: ROLE_W]; // R23
        main_nxt.sf = word[0 +: SF_W];
      end
    end
    // first-order dc tracker per channel
    est_l = main_r.avl[31:HPF_FRAC];
    est_r = main_r.avr[31:HPF_FRAC];
    dl = {sample_left[23], sample_left} - {est_l[23], est_l};
    dr = {sample_right[23], sample_right} - {est_r[23], est_r};
    if (sample_valid) begin
      main_nxt.avl = main_r.avl + {{7{dl[24]}}, dl};
      main_nxt.avr = main_r.avr + {{7{dr[24]}}, dr};
      main_nxt.cl = main_r.bypass ? sample_left : sat24(dl); // R13
      main_nxt.cr = main_r.bypass ? sample_right : sat24(dr); // R13
    end
    // each frame request takes the newest pair; words stay put till next
    main_nxt.req_q = req_s;
    if (req_s != main_r.req_q) begin
      main_nxt.hl = main_r.cl;
      main_nxt.hr = main_r.cr;
      main_nxt.ack = !main_r.ack;
      tick = 1'b1;
    end
    // a new overflow wins; one extra count covers the part-period start
    ovf_ev = overflow_left || overflow_right;
    if (ovf_ev) begin
      main_nxt.ocnt = OVF_HOLD + 14'h0001; // R12
    end else if (tick && main_r.ocnt != '0) begin
      main_nxt.ocnt = main_r.ocnt - 14'h0001;
    end
    main_nxt.ovf = ovf_ev || (main_nxt.ocnt != '0); // R12
    // restore reloads control fields; power-down clears the rest and reloads them too
    if (!nrst) begin
      main_nxt = '0; // R11
    end
    if (!nrst || (wr_en && ok_at && ix == AT_GAIN &&
        !word[RESTORE_BIT])) begin
      main_nxt.gain = GAIN_RST; // R16
      main_nxt.chan = CHAN_RST;
      main_nxt.bypass = 1'b0;
      main_nxt.rsn = 1'b1;
      main_nxt.role = ROLE_RST;
      main_nxt.sf = SF_RST;
    end
  end

  // main clock state
  always_ff @(posedge clock) begin
    main_r <= main_nxt;
  end

  // link clocks, framing, lock supervision and serial output
  always_comb begin
    link_nxt = link_r;
    master = l_role != ROLE_SLAVE; // R23
    hp = (l_role == ROLE_M256) ? HP256 :
      (l_role == ROLE_M384) ? HP384 : HP512;
    rise = bit_s && !link_r.bit_q;
    fall = 1'b0;
    lre = 1'b0;
    lv = link_r.fo;
    hsz = HALF64;
    link_nxt.bit_q = bit_s;
    link_nxt.frm_q = frm_s;
    link_nxt.ack_q = ack_s;
    if (master) begin
      if (link_r.div >= hp - 3'h1) begin
        link_nxt.div = '0;
        link_nxt.bo = !link_r.bo; // R24
        fall = link_r.bo;
      end else begin
        link_nxt.div = link_r.div + 3'h1;
      end
      lre = fall && (link_r.pos >= HALF64 - 6'h01); // R24
      lv = link_r.fo ^ lre;
      link_nxt.fo = lv; // R4
    end else begin
      fall = !bit_s && link_r.bit_q; // R3
      lre = frm_s != link_r.frm_q; // R5
      lv = frm_s;
      if (link_r.half == HALF48) begin
        hsz = HALF48; // R25
      end
    end
    // bit clock period in system clocks, saturating when it stops
    if (rise) begin
      link_nxt.bper = link_r.bcnt + 5'h01;
      link_nxt.bcnt = '0;
    end else if (link_r.bcnt != '1) begin
      link_nxt.bcnt = link_r.bcnt + 5'h01;
    end
    // bit position within the channel half
    if (lre) begin
      link_nxt.half = fall ? link_r.pos + 6'h01 : link_r.pos;
      link_nxt.pos = '0; // R3
    end else if (fall && link_r.pos != POS_MAX) begin
      link_nxt.pos = link_r.pos + 6'h01; // R3
    end
    left = (l_sf == SF_I2S24) ? !lv : lv; // R1
    fs = lre && left;
    if (ack_s != link_r.ack_q) begin
      link_nxt.nl = main_r.hl;
      link_nxt.nr = main_r.hr;
    end
    // phase of the frame start against a free system clock count
    e = (link_r.ph == link_r.per - 10'h001) ? '0 :
      link_r.ph + 10'h001;
    dev = (e <= {1'b0, link_r.per[9:1]}) ? e : link_r.per - e; // R6
    lm = (hsz == HALF48) ? LIM48 : LIM64;
    lim = {5'h00, lm} * {3'h0, link_r.bper};
    lost = dev > {2'h0, lim}; // R7 R9
    unique case (link_r.st)
      SYN_ACQ: begin
        if (fs) begin
          link_nxt.ph = '0;
          link_nxt.st = SYN_MEAS;
        end
      end
      SYN_MEAS: begin
        link_nxt.ph = link_r.ph + 10'h001;
        if (fs) begin
          link_nxt.per = link_r.ph + 10'h001;
          link_nxt.ph = '0;
          link_nxt.st = SYN_RUN;
        end
      end
      SYN_RUN: begin
        link_nxt.ph = e;
        if (fs && lost) begin
          link_nxt.st = SYN_ACQ; // R7
        end
      end
      default: link_nxt.st = SYN_ACQ;
    endcase
    if (master) begin
      link_nxt.st = SYN_RUN;
    end
    if (!l_rsn) begin
      link_nxt.st = SYN_ACQ; // R14
    end
    mute = link_nxt.st != SYN_RUN;
    if (fs) begin
      link_nxt.req = !link_r.req;
      link_nxt.wl = link_r.nl;
      link_nxt.wr = link_r.nr;
    end
    if (mute) begin
      link_nxt.wl = ZERO_CODE; // R8
      link_nxt.wr = ZERO_CODE;
    end
    // where the word starts in the half and how long it is
    unique case (l_sf)
      SF_I2S24: st0 = 6'h01; // R1
      SF_RJ24: st0 = hsz - WORD24; // R2
      SF_RJ16: st0 = hsz - WORD16; // R2
      default: st0 = '0; // R1
    endcase
    wn = (l_sf == SF_RJ16) ? WORD16 : WORD24;
    k = link_nxt.pos - st0;
    inr = (link_nxt.pos >= st0) && (k < wn);
    w = left ? link_nxt.wl : link_nxt.wr;
    bitv = inr ? w[5'(WORD24 - 6'h01 - k)] : 1'b0;
    link_nxt.dout = bitv; // R3
    link_nxt.oe = 1'b1;
    link_nxt.boe = master; // R24
    if (!l_nrst) begin
      link_nxt = '0; // R11
      link_nxt.st = SYN_ACQ;
    end
  end

  assign ev = fall || lre;

  // link clock state
  always_ff @(posedge system_clock_in) begin
    link_r <= link_nxt;
  end

  // outputs straight from state flops
  assign bit_clock_out = link_r.bo;
  assign bit_clock_oe = link_r.boe;
  assign frame_clock_out = link_r.fo;
  assign frame_clock_oe = link_r.boe;
  assign data_out = link_r.dout;
  assign data_out_oe = link_r.oe;
  assign overflow_flag = main_r.ovf;
  assign gain_setting = main_r.gain;
  assign input_channel_select = main_r.chan;
  assign dc_filter_bypass = main_r.bypass;
  assign resync_request_n = main_r.rsn;
  assign link_role_select = main_r.role;
  assign sample_format = main_r.sf;

  // checks on the control side
  chk_mode_write: assert property (@(posedge clock) disable iff (!nrst) // R20
    (wr_en && ok_at && ix == AT_MODE) |=>
      (sample_format == $past(word[2:0]) &&
       resync_request_n == $past(word[RSYNC_BIT])))
    else $error("mode register not latched after sixteenth clock");
  chk_bad_index: assert property (@(posedge clock) disable iff (!nrst) // R22
    (wr_en && !ok_at) |=> ($stable(sample_format) &&
      $stable(gain_setting) && $stable(link_role_select)))
    else $error("word with bad index changed a register");
  chk_restore_all: assert property (@(posedge clock) disable iff (!nrst) // R16
    (wr_en && ok_at && ix == AT_GAIN && !word[RESTORE_BIT]) |=>
      (sample_format == SF_RST && link_role_select == ROLE_RST &&
       resync_request_n && !dc_filter_bypass))
    else $error("restore did not reload defaults");
  chk_ovf_hold: assert property (@(posedge clock) disable iff (!nrst) // R12
    $fell(overflow_flag) |-> ($past(main_r.ocnt) == 14'h0001 &&
      main_r.ocnt == '0))
    else $error("overflow flag dropped before hold expired");
  chk_bypass_pass: assert property (@(posedge clock) disable iff (!nrst) // R13
    (sample_valid && main_r.bypass) |=> main_r.cl == $past(sample_left))
    else $error("bypassed sample was altered");

  // checks on the link side
  chk_frame_edge: assert property (@(posedge system_clock_in) // R4
    disable iff (!l_nrst)
    (link_r.boe && $changed(frame_clock_out)) |-> $fell(bit_clock_out))
    else $error("master frame clock moved off a bit clock fall");
  chk_data_edge: assert property (@(posedge system_clock_in) // R3
    disable iff (!l_nrst)
    ($changed(data_out) && $past(link_r.oe) && $stable(l_sf) &&
     $stable(link_r.st)) |-> $past(ev))
    else $error("data changed without a clock edge");
  chk_sync_lost: assert property (@(posedge system_clock_in) // R7
    disable iff (!l_nrst)
    (fs && lost && !master && link_r.st == SYN_RUN) |=>
      (link_r.st == SYN_ACQ && link_r.wl == ZERO_CODE))
    else $error("large drift did not drop lock");
  chk_sync_keep: assert property (@(posedge system_clock_in) // R9
    disable iff (!l_nrst)
    (fs && !lost && !master && l_rsn && link_r.st == SYN_RUN) |=>
      link_r.st == SYN_RUN)
    else $error("small drift broke the stream");
  chk_resync_hold: assert property (@(posedge system_clock_in) // R14
    disable iff (!l_nrst)
    !l_rsn |=> (link_r.st == SYN_ACQ && link_r.wr == ZERO_CODE))
    else $error("resync request did not hold the stream");
  chk_reset_off: assert property (@(posedge system_clock_in) // R11
    !l_nrst |=> (!data_out_oe && !bit_clock_oe && !frame_clock_oe))
    else $error("outputs driven during power-down");
  chk_role_drive: assert property (@(posedge system_clock_in) // R23
    disable iff (!l_nrst)
    (master && $stable(l_role)) |=> (bit_clock_oe && frame_clock_oe))
    else $error("master role does not drive link clocks");

  cov_ctrl_write: cover property (@(posedge clock) wr_en && ok_at);
  cov_master_frame: cover property (@(posedge system_clock_in)
    fs && master);
  cov_slave_lock: cover property (@(posedge system_clock_in)
    link_r.st == SYN_MEAS ##1 link_r.st == SYN_RUN);
  cov_lock_lost: cover property (@(posedge system_clock_in)
    fs && lost && link_r.st == SYN_RUN && !master);
endmodule // sac_audio_port

/* testbench/sac_partner.sv */
/* sac_partner: audio processor model; makes slave bit and frame
   clocks from the link clock and captures both channel words.
   Assumes the bench resolves the clock wires from all drivers. */
`timescale 1ns/10ps
module sac_partner (
  input wire logic link_clk,
  input wire logic slave_on,
  input wire logic [3:0] stretch,
  input wire logic bclk,
  input wire logic fclk,
  input wire logic sdata,
  output logic bclk_drv,
  output logic fclk_drv,
  output logic [31:0] word_hi,
  output logic [31:0] word_lo,
  output int frames
);
  int hc = 0;
  int bits = 0;
  logic [31:0] sh = '0;
  logic last_f = 1'b0;
  initial begin
    bclk_drv = 1'b0;
    fclk_drv = 1'b0;
    word_hi = '0;
    word_lo = '0;
    frames = 0;
  end
  // slave clocks, derived from the link clock so they stay locked to it;
  // eight link clocks a bit clock, so a 64-bit frame is 512 link clocks
  always @(posedge link_clk) begin
    if (!slave_on) begin
      bclk_drv <= 1'b0; // clock stands still while not driving
      hc <= 0;
    end else if (hc == 3) begin
      hc <= 0;
      bclk_drv <= ~bclk_drv;
      if (bclk_drv) begin
        if (bits == 31 + (fclk_drv ? 0 : int'(stretch))) begin
          bits <= 0;
          fclk_drv <= ~fclk_drv;
        end else begin
          bits <= bits + 1;
        end
      end
    end else begin
      hc <= hc + 1;
    end
  end
  // capture on bit clock rise; one word per frame half, last 32 bits kept
  always @(posedge bclk) begin
    if (fclk != last_f) begin
      if (last_f) word_hi <= sh;
      else word_lo <= sh;
      if (fclk) frames <= frames + 1;
      sh <= {31'h0, sdata};
    end else begin
      sh <= {sh[30:0], sdata};
    end
    last_f <= fclk;
  end
endmodule // sac_partner

/* testbench/stereo_adc_audio_and_control_port_bench.sv */
/* stereo_adc_audio_and_control_port_bench: control port writes, link
   formats in the slave role, master rates, drift, overflow and reset checks.
   Assumes sac_partner models the far side of the link. */
`timescale 1ns/10ps
module stereo_adc_audio_and_control_port_bench
  import sac_pkg::*;
;
  localparam logic [23:0] SL = 24'hA5C3E1;
  localparam logic [23:0] SR = 24'h5A3C1E;
  localparam logic [15:0] DEF = {GAIN_RST, CHAN_RST, 1'b0, 1'b1,
    ROLE_RST, SF_RST};
  logic clock, nrst, sys_clk, sel_n, cclk, cdata, sv, ovl, ovr;
  logic slave_on, bclk_w, fclk_w, bclk_drv, fclk_drv;
  logic [3:0] stretch;
  logic [23:0] sl, sr;
  logic bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe;
  logic data_out, data_out_oe, overflow_flag, dc_filter_bypass;
  logic resync_request_n;
  logic [5:0] gain_setting;
  logic [2:0] input_channel_select, sample_format;
  logic [1:0] link_role_select;
  logic [31:0] word_hi, word_lo;
  logic [2:0] fmts [4] = '{SF_I2S24, SF_RJ24, SF_RJ16, SF_LJ24};
  logic pb = 1'b0;
  logic pf = 1'b0;
  int frames, mismatches = 0, num_checks = 0, cycles = 0;
  int fl_cnt = 0, frame_len = 0, lr_bad = 0;
  // resolve the two-way clock wires
  assign bclk_w = bit_clock_oe ? bit_clock_out : bclk_drv;
  assign fclk_w = frame_clock_oe ? frame_clock_out : fclk_drv;
  sac_audio_port #(.OVF_HOLD(14'h0008)) sac_audio_port_i (
    .clock(clock), .nrst(nrst), .system_clock_in(sys_clk),
    .ctrl_select_n(sel_n), .ctrl_clock(cclk), .ctrl_data_in(cdata),
    .sample_left(sl), .sample_right(sr), .sample_valid(sv),
    .overflow_left(ovl), .overflow_right(ovr), .bit_clock_in(bclk_w),
    .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
    .frame_clock_in(fclk_w), .frame_clock_out(frame_clock_out),
    .frame_clock_oe(frame_clock_oe), .data_out(data_out),
    .data_out_oe(data_out_oe), .overflow_flag(overflow_flag),
    .gain_setting(gain_setting),
    .input_channel_select(input_channel_select),
    .dc_filter_bypass(dc_filter_bypass),
    .resync_request_n(resync_request_n),
    .link_role_select(link_role_select), .sample_format(sample_format));
  sac_partner sac_partner_i (
    .link_clk(sys_clk), .slave_on(slave_on), .stretch(stretch),
    .bclk(bclk_w), .fclk(fclk_w), .sdata(data_out),
    .bclk_drv(bclk_drv), .fclk_drv(fclk_drv), .word_hi(word_hi),
    .word_lo(word_lo), .frames(frames));
  // clocks, link clock out of phase with the main one
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    sys_clk = 1'b0;
    #1.7;
    forever #3 sys_clk = ~sys_clk;
  end
  // master clock monitor: frame length and frame edges against falls
  always @(posedge sys_clk) begin
    fl_cnt++;
    if (frame_clock_out !== pf) begin
      if (!(pb === 1'b1 && bit_clock_out === 1'b0)) lr_bad++;
      if (frame_clock_out === 1'b1) begin
        frame_len = fl_cnt;
        fl_cnt = 0;
      end
    end
    pb = bit_clock_out;
    pf = frame_clock_out;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_frames(input int n);
    int f;
    f = frames;
    wait (frames >= f + n);
    tick(1);
  endtask
  // one control word, MSB first, select high afterwards
  task automatic ctrl_write(input logic [15:0] w);
    sel_n = 1'b0;
    tick(3);
    for (int i = 15; i >= 0; i--) begin
      cdata = w[i];
      tick(3);
      cclk = 1'b1;
      tick(3);
      cclk = 1'b0;
    end
    tick(3);
    sel_n = 1'b1;
    tick(8);
  endtask
  task automatic regs(input logic [15:0] e);
    check({16'h0, gain_setting, input_channel_select, dc_filter_bypass,
      resync_request_n, link_role_select, sample_format}, {16'h0, e});
  endtask
  // change role and format with resync held, dc passed through
  task automatic mode(input logic [1:0] role, input logic [2:0] f);
    ctrl_write({1'b0, AT_MODE, 3'b100, role, f});
    ctrl_write({1'b0, AT_MODE, 3'b110, role, f});
    sv = 1'b1;
    tick(1);
    sv = 1'b0;
  endtask
  function automatic logic [31:0] half(input logic [2:0] f,
    input logic [23:0] s);
    case (f)
      SF_LJ24: half = {s, 8'h00};
      SF_I2S24: half = {1'b0, s, 7'h00};
      SF_RJ24: half = {8'h00, s};
      default: half = {16'h0000, s[23:8]};
    endcase
  endfunction
  task automatic check_link(input logic [2:0] f, input logic zero);
    logic i2s;
    i2s = (f == SF_I2S24);
    check(i2s ? word_lo : word_hi, zero ? 32'h0 : half(f, SL));
    check(i2s ? word_hi : word_lo, zero ? 32'h0 : half(f, SR));
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    sel_n = 1'b1;
    {cclk, cdata, sv, ovl, ovr} = 5'h00;
    sl = SL;
    sr = SR;
    slave_on = 1'b1;
    stretch = 4'h0;
    tick(4);
    check({31'h0, data_out_oe}, 32'h0);
    nrst = 1'b1;
    tick(3);
    check({31'h0, data_out_oe}, 32'h1);
    regs(DEF);
    ctrl_write({1'b0, AT_GAIN, 8'h6A});
    ctrl_write({1'b0, AT_CHAN, 8'h05});
    ctrl_write({1'b1, AT_CHAN, 8'h02});
    ctrl_write({1'b0, 7'h30, 8'h02});
    regs({6'h2A, 3'h5, DEF[6:0]});
    ctrl_write({1'b0, AT_GAIN, 8'h3F});
    regs(DEF);
    foreach (fmts[i]) begin
      mode(ROLE_SLAVE, fmts[i]);
      wait_frames(5);
      check_link(fmts[i], 1'b0);
    end
    stretch = 4'h4;
    wait_frames(1);
    stretch = 4'h0;
    wait_frames(3);
    check_link(SF_LJ24, 1'b0);
    stretch = 4'h8;
    wait_frames(1);
    stretch = 4'h0;
    wait_frames(2);
    check_link(SF_LJ24, 1'b1);
    wait_frames(4);
    check_link(SF_LJ24, 1'b0);
    ctrl_write({1'b0, AT_MODE, 8'h85});
    wait_frames(3);
    check_link(SF_LJ24, 1'b1);
    slave_on = 1'b0;
    for (int r = 1; r < 4; r++) begin
      mode(r[1:0], SF_LJ24);
      lr_bad = 0;
      wait_frames(4);
      check(frame_len, 128 * (r + 1));
      check(lr_bad, 0);
      check_link(SF_LJ24, 1'b0);
    end
    for (int c = 0; c < 2; c++) begin
      {ovr, ovl} = c[0] ? 2'b10 : 2'b01;
      tick(1);
      {ovr, ovl} = 2'b00;
      tick(4);
      check({31'h0, overflow_flag}, 32'h1);
      wait_frames(7);
      check({31'h0, overflow_flag}, 32'h1);
      wait_frames(3);
      check({31'h0, overflow_flag}, 32'h0);
    end
    nrst = 1'b0;
    tick(4);
    check({31'h0, data_out_oe}, 32'h0);
    regs(DEF);
    give_verdict();
  end
endmodule // stereo_adc_audio_and_control_port_bench
